// [opl_cfg.svh]
// Register map, field positions and masks of the power loop configuration slice
`ifndef OPL_CFG_SVH
`define OPL_CFG_SVH

// Bus geometry
`define OPL_APB_ADDR_W     12
`define OPL_IDX_W          8

// Register indices, byte address is four times the index
`define OPL_IDX_LP_HIGH    8'h3f
`define OPL_IDX_LP_LOW     8'h40
`define OPL_IDX_CLK2       8'h41
`define OPL_IDX_STEP2      8'h42
`define OPL_IDX_FILT2      8'h43
`define OPL_IDX_CLK1       8'h44

// Writable bit masks, reserved bits stay zero
`define OPL_MASK_LP_HIGH   8'h1f
`define OPL_MASK_FULL      8'hff
`define OPL_MASK_STEP2     8'hcf
`define OPL_MASK_FILT2     8'hef

// Field positions
`define OPL_LP_HIGH_MSB    4
`define OPL_STEP_MSB       7
`define OPL_START_SEL_MSB  3
`define OPL_CKDIV_MSB      1
`define OPL_DEC_MSB        7
`define OPL_LINE_BIT       3
`define OPL_WAIT_MSB       2
`define OPL_HOLD_BIT       0

// Clock count table exponents
`define OPL_EXP_LONG       5
`define OPL_EXP_SHORT      4

`endif

// [opl_pkg.sv]
// Types shared by the power loop configuration modules
package opl_pkg;

	typedef enum logic [1:0] {
		PH_IDLE     = 2'b00,
		PH_PRESCALE = 2'b01,
		PH_DIVIDED  = 2'b10
	} opl_phase_t;

	typedef struct packed {
		logic [7:0] lpHigh;
		logic [7:0] lpLow;
		logic [7:0] clkCounts2;
		logic [7:0] stepDiv2;
		logic [7:0] filtGate2;
		logic [7:0] clkCounts1;
	} opl_regs_t;

	typedef struct packed {
		logic       ready;
		logic       err;
		logic [7:0] rdata;
	} opl_apb_state_t;

	typedef struct packed {
		opl_regs_t  regs;
		logic       lpMeta;
		logic       lpSync;
		logic       lineMeta;
		logic       lineSync;
		logic       runPrev;
		opl_phase_t phase;
		logic [7:0] preCnt;
		logic [3:0] divCnt;
		logic       loopTick;
		logic       dividerOn;
		logic [9:0] driveCurrent;
		logic       driverOut;
		logic [12:0] target;
		logic [7:0] startCnt;
		logic [7:0] midCnt;
		logic [7:0] finestCnt;
		logic [7:0] divEnCnt;
		logic [31:0] ch1Counts;
		logic [5:0] stepSize;
		logic [4:0] divider;
		logic [7:0] decimation;
		logic [1:0] startDelay;
		logic       hold;
		logic       lineGated;
	} opl_core_state_t;

endpackage

// [opl_reg_if.sv]
// Register access carrier between the APB port and the register bank
interface opl_reg_if;
	logic [11:0] addr;
	logic        wrStrobe;
	logic [7:0]  wrData;
	logic [7:0]  rdData;
	logic        hit;

	modport port (output addr, output wrStrobe, output wrData, input rdData, input hit);
	modport bank (input addr, input wrStrobe, input wrData, output rdData, output hit);
endinterface

// [opl_count_decode.sv]
// Two-bit code to clock count table: 0, then 2^(BASE_EXP-1+code)-1
module opl_count_decode #(
	parameter int BASE_EXP = 5
) (
	// Code in
	input  logic [1:0] code,
	// Count out
	output logic [7:0] count
);
	logic [8:0] full;

	// Code zero means no clocks at all
	always_comb begin
		full  = (9'h001 << (BASE_EXP - 1 + int'(code))) - 9'h001;
		count = (code == 2'h0) ? 8'h00 : full[7:0];
	end
endmodule

// [opl_apb_port.sv]
// APB slave handshake for the byte-wide configuration registers
module opl_apb_port (
	// Clock and reset
	input  logic        clk,
	input  logic        reset,
	// APB
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [11:0] paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	// Register bank
	opl_reg_if.port     regs
);
	opl_pkg::opl_apb_state_t s;
	opl_pkg::opl_apb_state_t n;
	logic                    take;

	// One wait state keeps pready and prdata on flip-flops
	assign take          = psel && penable && !s.ready;
	assign regs.addr     = paddr;
	assign regs.wrData   = pwdata[7:0];
	assign regs.wrStrobe = take && pwrite && regs.hit;

	// Answer the access; unmapped addresses answer with an error
	always_comb begin
		n       = s;
		n.ready = 1'b0;
		n.err   = 1'b0;
		if (take) begin
			n.ready = 1'b1;
			n.err   = !regs.hit;
			n.rdata = (!pwrite && regs.hit) ? regs.rdData : 8'h00;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Upper data bits read as zero
	assign prdata  = {24'h000000, s.rdata};
	assign pready  = s.ready;
	assign pslverr = s.err;
endmodule

// [opl_power_loop_config.sv]
// Power loop configuration registers of channels 0, 1 and 2, and channel 2 loop sequencing
`include "opl_cfg.svh"
module opl_power_loop_config (
	// Clock and reset
	input  logic        clk,
	input  logic        reset,
	// APB slave
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [11:0] paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	// Pins from outside the clock domain
	input  logic        lowPowerSelectInput,
	input  logic        lineClockIn,
	// Loop datapath, same clock
	input  logic        loopEnableCh2,
	input  logic        driveRequestCh2,
	input  logic [9:0]  loopCodeCh2,
	input  logic [9:0]  storedOutputCodeCh2,
	input  logic [12:0] normalTargetCh0,
	// Channel 2 clock counts
	output logic [7:0]  startClockCountCh2,
	output logic [7:0]  middleClockCountCh2,
	output logic [7:0]  finestStepClockCountCh2,
	output logic [7:0]  dividerEnableCountCh2,
	// Channel 2 loop settings
	output logic [5:0]  firstStepSizeCh2,
	output logic [4:0]  loopClockDividerCh2,
	output logic [7:0]  filterDecimationCh2,
	output logic [1:0]  loopStartDelayCh2,
	output logic        loopHoldCh2,
	output logic        lineGatedOutputCh2,
	// Channel 2 loop activity
	output logic        loopTickCh2,
	output logic        dividerEnabledCh2,
	output logic [9:0]  driveCurrentCh2,
	output logic        driverOutputCh2,
	// Channel 0 target and channel 1 counts
	output logic [12:0] loopTargetCh0,
	output logic [31:0] clockCountsCh1
);
	opl_pkg::opl_core_state_t s;
	opl_pkg::opl_core_state_t n;

	opl_reg_if regIf ();

	logic [7:0] regIdx;
	logic       aligned;
	logic [1:0] codes [8];
	logic [7:0] counts [8];
	logic [1:0] stepCode;
	logic [1:0] divCode;
	logic [2:0] decCode;
	logic [1:0] startSel;
	logic [4:0] divLimit;

	// Bus handshake lives in its own small module
	opl_apb_port apbPort (
		.clk     (clk),
		.reset   (reset),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.regs    (regIf.port)
	);

	// Word aligned index; upper address bits must be zero
	assign regIdx  = regIf.addr[9:2];
	assign aligned = (regIf.addr[1:0] == 2'h0) && (regIf.addr[11:10] == 2'h0);

	// read decode, reserved bits already zero
	always_comb begin
		regIf.hit    = 1'b0;
		regIf.rdData = 8'h00;
		if (!aligned) begin
			regIf.hit = 1'b0;
		end else if (regIdx == `OPL_IDX_LP_HIGH) begin
			regIf.hit    = 1'b1;
			regIf.rdData = s.regs.lpHigh;
		end else if (regIdx == `OPL_IDX_LP_LOW) begin
			regIf.hit    = 1'b1;
			regIf.rdData = s.regs.lpLow;
		end else if (regIdx == `OPL_IDX_CLK2) begin
			regIf.hit    = 1'b1;
			regIf.rdData = s.regs.clkCounts2;
		end else if (regIdx == `OPL_IDX_STEP2) begin
			regIf.hit    = 1'b1;
			regIf.rdData = s.regs.stepDiv2;
		end else if (regIdx == `OPL_IDX_FILT2) begin
			regIf.hit    = 1'b1;
			regIf.rdData = s.regs.filtGate2;
		end else if (regIdx == `OPL_IDX_CLK1) begin
			regIf.hit    = 1'b1;
			regIf.rdData = s.regs.clkCounts1;
		end
	end

	// Eight two-bit count fields: four of channel 2, four of channel 1
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : gCount
			localparam int POS = 7 - 2 * (gi % 4);
			localparam int EXP = ((gi % 4) == 0 || (gi % 4) == 3) ?
				`OPL_EXP_LONG : `OPL_EXP_SHORT;
			if (gi < 4) begin : gCh2
				assign codes[gi] = s.regs.clkCounts2[POS -: 2];
			end else begin : gCh1
				assign codes[gi] = s.regs.clkCounts1[POS -: 2];
			end
			opl_count_decode #(
				.BASE_EXP (EXP + 1)
			) countDecode (
				.code  (codes[gi]),
				.count (counts[gi])
			);
		end
	endgenerate

	// Field slices of the channel 2 control registers
	assign stepCode = s.regs.stepDiv2[`OPL_STEP_MSB -: 2];
	assign startSel = s.regs.stepDiv2[`OPL_START_SEL_MSB -: 2];
	assign divCode  = s.regs.stepDiv2[`OPL_CKDIV_MSB -: 2];
	assign decCode  = s.regs.filtGate2[`OPL_DEC_MSB -: 3];
	assign divLimit = s.divider - 5'h01;

	// Next state of the whole bank
	always_comb begin
		n          = s;
		n.loopTick = 1'b0;

		// Two flops on each pin before any use
		n.lpMeta   = lowPowerSelectInput;
		n.lpSync   = s.lpMeta;
		n.lineMeta = lineClockIn;
		n.lineSync = s.lineMeta;

		// writes masked so reserved bits never store
		if (regIf.wrStrobe) begin
			if (regIdx == `OPL_IDX_LP_HIGH) begin
				n.regs.lpHigh = regIf.wrData & `OPL_MASK_LP_HIGH;
			end else if (regIdx == `OPL_IDX_LP_LOW) begin
				n.regs.lpLow = regIf.wrData & `OPL_MASK_FULL;
			end else if (regIdx == `OPL_IDX_CLK2) begin
				n.regs.clkCounts2 = regIf.wrData & `OPL_MASK_FULL;
			end else if (regIdx == `OPL_IDX_STEP2) begin
				n.regs.stepDiv2 = regIf.wrData & `OPL_MASK_STEP2;
			end else if (regIdx == `OPL_IDX_FILT2) begin
				n.regs.filtGate2 = regIf.wrData & `OPL_MASK_FILT2;
			end else if (regIdx == `OPL_IDX_CLK1) begin
				n.regs.clkCounts1 = regIf.wrData & `OPL_MASK_FULL;
			end
		end

		n.startCnt  = counts[0];
		n.midCnt    = counts[1];
		n.finestCnt = counts[2];
		n.divEnCnt  = counts[3];
		n.ch1Counts = {counts[4], counts[5], counts[6], counts[7]};

		// first step size in output LSBs
		n.stepSize = (stepCode == 2'h0) ? 6'h01 : (6'h04 << stepCode);
		n.divider = (divCode == 2'h0) ? 5'h01 : (5'h02 << divCode);
		n.decimation = 8'h01 << decCode;
		n.startDelay = s.regs.filtGate2[`OPL_WAIT_MSB -: 2];
		n.hold       = s.regs.filtGate2[`OPL_HOLD_BIT];
		n.lineGated  = s.regs.filtGate2[`OPL_LINE_BIT];

		// Loop sequencing; start is the rising edge of the enable
		n.runPrev = loopEnableCh2;
		if (!loopEnableCh2) begin
			n.phase     = opl_pkg::PH_IDLE;
			n.dividerOn = 1'b0;
		end else if (!s.runPrev) begin
			n.phase     = opl_pkg::PH_PRESCALE;
			n.preCnt    = 8'h00;
			n.divCnt    = 4'h0;
			n.dividerOn = 1'b0;
			// output code chosen at loop start
			case (startSel)
				2'b00: n.driveCurrent = 10'h000;
				2'b01: n.driveCurrent = s.driveCurrent;
				2'b10: n.driveCurrent = storedOutputCodeCh2;
				default: n.driveCurrent = 10'h000;
			endcase
		end else if (!s.hold) begin
			case (s.phase)
				// undivided ticks until the enable count is reached
				opl_pkg::PH_PRESCALE: begin
					n.loopTick = 1'b1;
					if (s.preCnt >= s.divEnCnt) begin
						n.phase     = opl_pkg::PH_DIVIDED;
						n.dividerOn = 1'b1;
					end else begin
						n.preCnt = s.preCnt + 8'h01;
					end
				end
				opl_pkg::PH_DIVIDED: begin
					if ({1'b0, s.divCnt} >= divLimit) begin
						n.loopTick = 1'b1;
						n.divCnt   = 4'h0;
					end else begin
						n.divCnt = s.divCnt + 4'h1;
					end
				end
				default: begin
					n.phase = opl_pkg::PH_IDLE;
				end
			endcase
		end

		// held loop takes no ticks, so the code stays put
		if (n.loopTick) begin
			n.driveCurrent = loopCodeCh2;
		end

		// gate the driver with the synchronised line clock
		n.driverOut = driveRequestCh2 && (!s.lineGated || s.lineSync);

		// low-power target while the select pin is low
		if (s.lpSync) begin
			n.target = normalTargetCh0;
		end else begin
			n.target = {s.regs.lpHigh[`OPL_LP_HIGH_MSB:0], s.regs.lpLow};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state flops
	assign startClockCountCh2      = s.startCnt;
	assign middleClockCountCh2     = s.midCnt;
	assign finestStepClockCountCh2 = s.finestCnt;
	assign dividerEnableCountCh2   = s.divEnCnt;
	assign firstStepSizeCh2        = s.stepSize;
	assign loopClockDividerCh2     = s.divider;
	assign filterDecimationCh2     = s.decimation;
	assign loopStartDelayCh2       = s.startDelay;
	assign loopHoldCh2             = s.hold;
	assign lineGatedOutputCh2      = s.lineGated;
	assign loopTickCh2             = s.loopTick;
	assign dividerEnabledCh2       = s.dividerOn;
	assign driveCurrentCh2         = s.driveCurrent;
	assign driverOutputCh2         = s.driverOut;
	assign loopTargetCh0           = s.target;
	assign clockCountsCh1          = s.ch1Counts;
endmodule

// [opl_power_loop_config_asserts.sv]
// Concurrent checks on the power loop configuration slice ports
module opl_power_loop_config_asserts (
	// Clock and reset
	input logic        clk,
	input logic        reset,
	// Bus answer
	input logic        pready,
	input logic [31:0] prdata,
	// Line pin and channel 2 outputs
	input logic        lineClockIn,
	input logic [7:0]  startClockCountCh2,
	input logic [7:0]  middleClockCountCh2,
	input logic [4:0]  loopClockDividerCh2,
	input logic [7:0]  filterDecimationCh2,
	input logic [5:0]  firstStepSizeCh2,
	input logic        lineGatedOutputCh2,
	input logic        driverOutputCh2,
	input logic        loopHoldCh2,
	input logic        loopTickCh2,
	input logic [9:0]  driveCurrentCh2
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic [1:0] age_q;
	// Edges since reset; decoded outputs read zero until the first one
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			age_q <= 2'h0;
		end else if (age_q != 2'h3) begin
			age_q <= age_q + 2'h1;
		end
	end
	a_start_table: assert property (
		age_q == 2'h3 |-> startClockCountCh2 inside {8'h00, 8'h3f, 8'h7f, 8'hff})
		else $error("start count off its table");
	a_middle_table: assert property (
		age_q == 2'h3 |-> middleClockCountCh2 inside {8'h00, 8'h1f, 8'h3f, 8'h7f})
		else $error("middle count off its table");
	a_divider_table: assert property (
		age_q == 2'h3 |-> loopClockDividerCh2 inside {5'h01, 5'h04, 5'h08, 5'h10})
		else $error("divider off its table");
	a_decim_power: assert property (
		age_q == 2'h3 |-> $onehot(filterDecimationCh2))
		else $error("decimation not a power of two");
	a_step_table: assert property (
		age_q == 2'h3 |-> firstStepSizeCh2 inside {6'h01, 6'h08, 6'h10, 6'h20})
		else $error("first step off its table");
	// Pin passes two sync flops and one register, so look three and four back
	a_line_gate: assert property (
		lineGatedOutputCh2 && $past(lineGatedOutputCh2, 3) && !$past(lineClockIn, 3)
		&& !$past(lineClockIn, 4) |-> !driverOutputCh2)
		else $error("channel 2 driven while line clock low");
	a_hold_freeze: assert property (
		loopHoldCh2 && $past(loopHoldCh2) && $past(loopHoldCh2, 3)
		|-> !loopTickCh2 && $stable(driveCurrentCh2))
		else $error("loop moved while held");
	a_read_answer: assert property (
		pready |-> prdata[31:8] == 24'h000000 ##1 !pready)
		else $error("bus answer not a clean one-cycle pulse");
endmodule

bind opl_power_loop_config opl_power_loop_config_asserts i_chk (.*);

// [opl_power_loop_config_tb.sv]
// Self-checking bench for the power loop configuration slice
module opl_power_loop_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Design ports, named alike so the instance connects by name
	logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, clockCountsCh1;
	logic        pready, pslverr, lowPowerSelectInput = 1'b1, lineClockIn = 1'b0;
	logic        loopEnableCh2 = 1'b0, driveRequestCh2 = 1'b0, loopHoldCh2;
	logic        lineGatedOutputCh2, loopTickCh2, dividerEnabledCh2, driverOutputCh2;
	logic [9:0]  loopCodeCh2 = 10'h000, storedOutputCodeCh2 = 10'h000, driveCurrentCh2;
	logic [12:0] normalTargetCh0 = 13'h0000, loopTargetCh0;
	logic [7:0]  startClockCountCh2, middleClockCountCh2, finestStepClockCountCh2;
	logic [7:0]  dividerEnableCountCh2, filterDecimationCh2;
	logic [5:0]  firstStepSizeCh2;
	logic [4:0]  loopClockDividerCh2;
	logic [1:0]  loopStartDelayCh2;
	// Bench state and expectation tables
	int          miscompares = 0, tests_run = 0, seed = 96986;
	logic [33:0] noteQ [$];
	logic [33:0] note;
	logic [7:0]  hi, lo;
	logic [9:0]  sc, lc;
	logic [11:0] addr [6] = '{12'h0fc, 12'h100, 12'h104, 12'h108, 12'h10c, 12'h110};
	logic [7:0]  mask [6] = '{8'h1f, 8'hff, 8'hff, 8'hcf, 8'hef, 8'hff};
	logic [7:0]  longT [4] = '{8'h00, 8'h3f, 8'h7f, 8'hff};
	logic [7:0]  shortT [4] = '{8'h00, 8'h1f, 8'h3f, 8'h7f};
	logic [7:0]  divT [4] = '{8'h01, 8'h04, 8'h08, 8'h10};
	logic [7:0]  stepT [4] = '{8'h01, 8'h08, 8'h10, 8'h20};

	opl_power_loop_config i_dut (.*);

	// 50 ns period
	always #25 clk = ~clk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One transfer; holds the request until pready, then one idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
			input logic [32:0] e);
		noteQ.push_back({w, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Answer watcher: oldest note against each bus answer
	always @(posedge clk) begin
		if (pready === 1'b1 && noteQ.size() > 0) begin
			note = noteQ.pop_front();
			check("pslverr", pslverr, note[32]);
			if (!note[33]) check("prdata", prdata, note[31:0]);
		end
	end

	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// reset values, reserved bits, refused addresses
		for (int i = 0; i < 6; i++) apb(1'b0, addr[i], 8'h00, 33'h0);
		for (int i = 0; i < 6; i++) begin
			hi = 8'($random(seed));
			wr(addr[i], hi);
			apb(1'b0, addr[i], 8'h00, {25'h0, hi & mask[i]});
		end
		apb(1'b0, 12'h114, 8'h00, {1'b1, 32'h0});
		apb(1'b1, 12'h105, 8'hff, {1'b1, 32'h0});
		for (int c = 0; c < 4; c++) begin
			wr(12'h104, {c[1:0], c[1:0], c[1:0], c[1:0]});
			wr(12'h108, {c[1:0], 4'h0, c[1:0]});
			wr(12'h110, {c[1:0], c[1:0], c[1:0], c[1:0]});
			settle(3);
			check("ch1Counts", clockCountsCh1, {longT[c], shortT[c], shortT[c], longT[c]});
			check("start", startClockCountCh2, longT[c]);
			check("middle", middleClockCountCh2, shortT[c]);
			check("finest", finestStepClockCountCh2, shortT[c]);
			check("divEnable", dividerEnableCountCh2, longT[c]);
			check("divider", loopClockDividerCh2, divT[c]);
			check("step", firstStepSizeCh2, stepT[c]);
		end
		for (int c = 0; c < 8; c++) begin
			wr(12'h10c, {c[2:0], 2'b00, c[1:0], 1'b0});
			settle(3);
			check("waitCode", loopStartDelayCh2, c[1:0]);
			check("decimation", filterDecimationCh2, 32'h1 << c);
		end
		driveRequestCh2 <= 1'b1;
		wr(12'h10c, 8'h08);
		settle(6);
		check("gatedLow", driverOutputCh2, 1'b0);
		lineClockIn <= 1'b1;
		settle(6);
		check("gatedHigh", driverOutputCh2, 1'b1);
		lineClockIn <= 1'b0;
		wr(12'h10c, 8'h00);
		settle(6);
		check("ungated", driverOutputCh2, 1'b1);
		hi = 8'($random(seed));
		lo = 8'($random(seed));
		wr(12'h0fc, hi);
		wr(12'h100, lo);
		normalTargetCh0 <= 13'($random(seed));
		lowPowerSelectInput <= 1'b0;
		settle(6);
		check("lowTarget", loopTargetCh0, {hi[4:0], lo});
		lowPowerSelectInput <= 1'b1;
		settle(6);
		check("normalTarget", loopTargetCh0, normalTargetCh0);
		// each start select, previous value from the run before
		sc = 10'($random(seed));
		lc = 10'($random(seed));
		storedOutputCodeCh2 <= sc;
		loopCodeCh2 <= lc;
		wr(12'h104, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(12'h108, {4'h0, c[1:0], 2'b00});
			loopEnableCh2 <= 1'b1;
			settle(1);
			check("startValue", driveCurrentCh2, c == 1 ? lc : (c == 2 ? sc : 10'h000));
			settle(6);
			loopEnableCh2 <= 1'b0;
			settle(2);
		end
		// hold freezes the output code, clearing resumes
		loopEnableCh2 <= 1'b1;
		wr(12'h10c, 8'h01);
		settle(3);
		loopCodeCh2 <= ~lc;
		settle(6);
		check("held", driveCurrentCh2, lc);
		check("holdBit", loopHoldCh2, 1'b1);
		wr(12'h10c, 8'h00);
		settle(6);
		check("resumed", driveCurrentCh2, 10'(~lc));
		close_out();
	end
endmodule
